// [src/epq_top.sv]
// event pin qualify and trip: qualifiers, pwm gating, soc pulses
// assumes synchronous pins, one 25 MHz clock, plain register port
`timescale 1ns/1ps
`default_nettype none
module epq_top
  import epq_pkg::*;
#(
  parameter int HSP_DIV = EPQ_HSP_DIV_DEF
) (
  input  wire logic                   clk,
  input  wire logic                   resetn,
  input  wire logic [EPQ_AW-1:0]      reg_addr,
  input  wire logic [EPQ_DW-1:0]      reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output var  logic [EPQ_DW-1:0]      reg_rdata,
  input  wire logic [EPQ_NPWM-1:0]    power_drive_protect_input_n,
  input  wire logic [EPQ_NPWM-1:0]    compare_trip_input_n,
  input  wire logic [EPQ_NPWM-1:0]    timer_compare_trip_input_n,
  input  wire logic                   ext_int_input,
  input  wire logic                   capture_input,
  input  wire logic                   timer_direction_input,
  output var  logic [EPQ_NPWM-1:0]    pwm_out,
  output var  logic [EPQ_NPWM-1:0]    pwm_oe,
  output wire logic                   conv_start_pulse_a_n,
  output wire logic                   conv_start_pulse_b_n,
  output var  logic [EPQ_GPO_W-1:0]   gpo_out,
  output wire logic                   timer_direction,
  output var  logic                   irq
);
  localparam logic [EPQ_DW-1:0] SOC_CYC =
    EPQ_DW'(EPQ_SOC_LOW_HSP * HSP_DIV);
  localparam logic [7:0] HSP_LAST = 8'(HSP_DIV - 1);

  logic [EPQ_QP_W-1:0] qual_period;
  logic [8:0]          qual_cnt;
  logic                sample_tick;
  logic [7:0]          hsp_cnt;
  logic                hsp_tick;
  logic [EPQ_DW-1:0]   pwm_period;
  logic [EPQ_DW-1:0]   pwm_cnt;
  logic [EPQ_DW-1:0]   duty [EPQ_NPWM];
  logic                cmp_oe [EPQ_NPWM];
  logic [EPQ_NQ-1:0]   pin_vec;
  logic [EPQ_NQ-1:0]   level;
  logic [EPQ_NQ-1:0]   prev_level;
  logic [EPQ_NEV-1:0]  ev;
  logic [EPQ_NEV-1:0]  status;
  logic [EPQ_NEV-1:0]  mask;
  logic [1:0]          soc_n;
  logic [EPQ_DW-1:0]   soc_cnt [2];
  logic [EPQ_DW-1:0]   next_rdata;
  logic                wr_ctrl;
  logic                wr_soc;
  logic                wr_gpo;
  logic                rd_status;

  epq_qual_if qif ();

  // ---------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------
  // strobes for the registers with side effects
  assign wr_ctrl   = reg_wr && reg_addr == EPQ_REG_CTRL;
  assign wr_soc    = reg_wr && reg_addr == EPQ_REG_SOC;
  assign wr_gpo    = reg_wr && reg_addr == EPQ_REG_GPO;
  assign rd_status = reg_rd && reg_addr == EPQ_REG_STATUS;

  // plain configuration registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      qual_period <= '0;
      pwm_period  <= EPQ_PERIOD_RST;
      mask        <= '0;
    end else if (reg_wr) begin
      if (reg_addr == EPQ_REG_CTRL)
        qual_period <= reg_wdata[EPQ_QP_LSB +: EPQ_QP_W];
      if (reg_addr == EPQ_REG_PERIOD)
        pwm_period <= reg_wdata;
      if (reg_addr == EPQ_REG_MASK)
        mask <= reg_wdata[EPQ_NEV-1:0];
    end
  end

  // general output: pin follows the write at the next edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) gpo_out <= '0;
    else if (wr_gpo) gpo_out <= reg_wdata[EPQ_GPO_W-1:0];
  end

  // ---------------------------------------------------------------
  // dividers
  // ---------------------------------------------------------------
  // qualifier strobe every 2n cycles; >= guards a shrinking field
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      qual_cnt    <= '0;
      sample_tick <= 1'b0;
    end else if (qual_period == '0) begin
      qual_cnt    <= '0;
      sample_tick <= 1'b0;
    end else if (qual_cnt >= {qual_period, 1'b0} - 9'h1) begin
      qual_cnt    <= '0;
      sample_tick <= 1'b1;
    end else begin
      qual_cnt    <= qual_cnt + 9'h1;
      sample_tick <= 1'b0;
    end
  end

  // high speed peripheral clock as an enable pulse
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hsp_cnt <= '0;
    end else if (hsp_cnt >= HSP_LAST) begin
      hsp_cnt <= '0;
    end else begin
      hsp_cnt <= hsp_cnt + 8'h1;
    end
  end
  assign hsp_tick = hsp_cnt >= HSP_LAST;

  assign qif.sample_en = sample_tick;
  assign qif.bypass    = qual_period == '0;

  // ---------------------------------------------------------------
  // input qualifiers
  // ---------------------------------------------------------------
  // every window of 2n cycles adds to the latency of each path
  assign pin_vec = {timer_direction_input, capture_input, ext_int_input,
                    timer_compare_trip_input_n, compare_trip_input_n,
                    power_drive_protect_input_n};

  for (genvar k = 0; k < EPQ_NQ; k++) begin : g_qual
    epq_qualifier u_qual (
      .clk    (clk),
      .resetn (resetn),
      .cfg    (qif.qual),
      .pin    (pin_vec[k]),
      .level  (level[k])
    );
  end
  assign timer_direction = level[EPQ_IN_TDIR];

  // ---------------------------------------------------------------
  // events and interrupt
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) prev_level <= '1;
    else         prev_level <= level;
  end

  // trips flag on falling edge, interrupt and capture on any edge
  always_comb begin
    ev = '0;
    for (int e = 0; e < EPQ_NEV; e++) begin
      if (e < EPQ_IN_XINT) ev[e] = prev_level[e] && !level[e];
      else                 ev[e] = prev_level[e] != level[e];
    end
  end

  // sticky status; a new event beats the read that clears it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)        status <= '0;
    else if (rd_status) status <= ev;
    else                status <= status | ev;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) irq <= 1'b0;
    else         irq <= |(status & mask);
  end

  // ---------------------------------------------------------------
  // pwm channels with trip gating
  // ---------------------------------------------------------------
  // shared period counter, moves only on peripheral clock ticks
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) pwm_cnt <= '0;
    else if (hsp_tick) begin
      if (pwm_cnt + 16'h1 >= pwm_period) pwm_cnt <= '0;
      else                               pwm_cnt <= pwm_cnt + 16'h1;
    end
  end

  for (genvar i = 0; i < EPQ_NPWM; i++) begin : g_pwm
    // duty register for this channel
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) duty[i] <= EPQ_DUTY_RST;
      else if (reg_wr && reg_addr == EPQ_REG_DUTY0 + 4'(i))
        duty[i] <= reg_wdata;
    end

    // enable bit: protect clears it, so release does not re-drive
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) cmp_oe[i] <= 1'b0;
      else if (!level[EPQ_IN_PDP + i]) cmp_oe[i] <= 1'b0;
      else if (wr_ctrl) cmp_oe[i] <= reg_wdata[EPQ_OE_LSB + i];
    end

    // duty 0 is off, duty at or above period is fully on
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn)                   pwm_out[i] <= 1'b0;
      else if (duty[i] == '0)        pwm_out[i] <= 1'b0;
      else if (duty[i] >= pwm_period) pwm_out[i] <= 1'b1;
      else pwm_out[i] <= pwm_cnt < duty[i];
    end

    // any low trip or protect level releases the pin at the next edge
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) pwm_oe[i] <= 1'b0;
      else pwm_oe[i] <= cmp_oe[i] && level[EPQ_IN_PDP + i] &&
                        level[EPQ_IN_CTRIP + i] &&
                        level[EPQ_IN_TTRIP + i];
    end
  end

  // ---------------------------------------------------------------
  // start of conversion pulses
  // ---------------------------------------------------------------
  // counted in system cycles so a partial first tick never shortens
  for (genvar j = 0; j < 2; j++) begin : g_soc
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        soc_n[j]   <= 1'b1;
        soc_cnt[j] <= '0;
      end else if (wr_soc && reg_wdata[j]) begin
        soc_n[j]   <= 1'b0;
        soc_cnt[j] <= SOC_CYC;
      end else if (soc_cnt[j] != '0) begin
        soc_cnt[j] <= soc_cnt[j] - 16'h1;
        if (soc_cnt[j] == 16'h1) soc_n[j] <= 1'b1;
      end
    end
  end
  assign conv_start_pulse_a_n = soc_n[0];
  assign conv_start_pulse_b_n = soc_n[1];

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  always_comb begin
    next_rdata = '0;
    unique case (reg_addr)
      EPQ_REG_CTRL: begin
        next_rdata[EPQ_QP_LSB +: EPQ_QP_W] = qual_period;
        for (int c = 0; c < EPQ_NPWM; c++)
          next_rdata[EPQ_OE_LSB + c] = cmp_oe[c];
      end
      EPQ_REG_PERIOD: next_rdata = pwm_period;
      EPQ_REG_SOC:    next_rdata[1:0] = ~soc_n;
      EPQ_REG_STATUS: next_rdata[EPQ_NEV-1:0] = status;
      EPQ_REG_MASK:   next_rdata[EPQ_NEV-1:0] = mask;
      EPQ_REG_LEVEL:  next_rdata[EPQ_NQ-1:0] = level;
      EPQ_REG_GPO:    next_rdata[EPQ_GPO_W-1:0] = gpo_out;
      default: begin
        for (int d = 0; d < EPQ_NPWM; d++)
          if (reg_addr == EPQ_REG_DUTY0 + 4'(d)) next_rdata = duty[d];
      end
    endcase
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)     reg_rdata <= '0;
    else if (reg_rd) reg_rdata <= next_rdata;
    else             reg_rdata <= '0;
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [9:0] ast_gap;
  logic       ast_qp_chg;
  logic [15:0] ast_soc_len;

  // helper: cycles since the last strobe, and field change marker
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ast_gap    <= '0;
      ast_qp_chg <= 1'b1;
    end else if (sample_tick) begin
      ast_gap    <= '0;
      ast_qp_chg <= wr_ctrl;
    end else begin
      ast_gap    <= ast_gap + 10'h1;
      if (wr_ctrl || qual_period == '0) ast_qp_chg <= 1'b1;
    end
  end

  // helper: length of the low phase of the first soc output
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)       ast_soc_len <= '0;
    else if (soc_n[0]) ast_soc_len <= '0;
    else               ast_soc_len <= ast_soc_len + 16'h1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_SAMPLE_PERIOD: assert property (
    (sample_tick && !ast_qp_chg) |->
      ast_gap == {1'b0, qual_period, 1'b0} - 10'h1)
    else $error("qualifier strobe spacing is not 2n cycles");
  AST_BYPASS: assert property (
    (qual_period == '0) [*3] |->
      level[EPQ_IN_XINT] == $past(ext_int_input, 2))
    else $error("zero period did not pass the pin straight");
  AST_TRIP_UNQ: assert property (
    (qual_period == '0 && !compare_trip_input_n[0]) |->
      ##[1:3] !pwm_oe[0])
    else $error("unqualified trip did not release the pin");
  AST_TRIP_QUAL: assert property (
    !level[EPQ_IN_CTRIP] |=> !pwm_oe[0])
    else $error("qualified trip did not release the pin");
  AST_PDP_OFF: assert property (
    !level[EPQ_IN_PDP] |=> (!cmp_oe[0] && !pwm_oe[0]))
    else $error("protect did not release the pin");
  AST_NO_RESUME: assert property (
    (!cmp_oe[0] && !wr_ctrl) |=> (!cmp_oe[0] ##1 !pwm_oe[0]))
    else $error("pin resumed without the enable bit");
  AST_SOC_FALL: assert property (
    (wr_soc && reg_wdata[0]) |=> !soc_n[0])
    else $error("soc did not fall within one cycle");
  AST_SOC_WIDTH: assert property (
    $rose(soc_n[0]) |-> ast_soc_len >= SOC_CYC)
    else $error("soc low phase too short");
  AST_PWM_LIMITS: assert property (
    (duty[0] == '0 |=> !pwm_out[0]) and
    ((duty[0] != '0 && duty[0] >= pwm_period) |=> pwm_out[0]))
    else $error("pwm full or zero duty not held");
  AST_GPO: assert property (
    wr_gpo |=> gpo_out == $past(reg_wdata[EPQ_GPO_W-1:0]))
    else $error("general output did not follow the write");
  AST_IRQ: assert property (
    ($changed(level[EPQ_IN_XINT]) && mask[EPQ_IN_XINT])
      ##1 mask[EPQ_IN_XINT] |=> irq)
    else $error("interrupt edge did not raise irq");

  COV_SOC: cover property ($rose(soc_n[0]));
  COV_TRIP: cover property ($fell(pwm_oe[0]));
  COV_IRQ: cover property ($rose(irq));
  COV_QUAL_ON: cover property (sample_tick && qual_period == 8'h01);
endmodule
`default_nettype wire

// [src/epq_pkg.sv]
// constants shared by the event pin qualify and trip block
// assumes a single 25 MHz system clock and a plain register port
package epq_pkg;
  // ---------------------------------------------------------------
  // widths and counts
  // ---------------------------------------------------------------
  localparam int EPQ_AW   = 4;
  localparam int EPQ_DW   = 16;
  localparam int EPQ_NQ   = 9;
  localparam int EPQ_NPWM = 2;
  localparam int EPQ_NEV  = 8;
  localparam int EPQ_QP_W = 8;
  localparam int EPQ_GPO_W = 8;
  localparam int EPQ_CLK_MHZ = 25;
  localparam int EPQ_HSP_DIV_DEF = 2;
  localparam int EPQ_SOC_LOW_HSP = 32;
  localparam logic [2:0] EPQ_QUAL_SAMPLES = 3'h6;

  // ---------------------------------------------------------------
  // register indices
  // ---------------------------------------------------------------
  localparam logic [EPQ_AW-1:0] EPQ_REG_CTRL   = 4'h0;
  localparam logic [EPQ_AW-1:0] EPQ_REG_PERIOD = 4'h1;
  localparam logic [EPQ_AW-1:0] EPQ_REG_DUTY0  = 4'h2;
  localparam logic [EPQ_AW-1:0] EPQ_REG_SOC    = 4'h4;
  localparam logic [EPQ_AW-1:0] EPQ_REG_STATUS = 4'h5;
  localparam logic [EPQ_AW-1:0] EPQ_REG_MASK   = 4'h6;
  localparam logic [EPQ_AW-1:0] EPQ_REG_LEVEL  = 4'h7;
  localparam logic [EPQ_AW-1:0] EPQ_REG_GPO    = 4'h8;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int EPQ_QP_LSB = 0;
  localparam int EPQ_OE_LSB = 8;
  localparam logic [EPQ_DW-1:0] EPQ_PERIOD_RST = 16'h00ff;
  localparam logic [EPQ_DW-1:0] EPQ_DUTY_RST   = 16'h0000;

  // ---------------------------------------------------------------
  // qualified input indices
  // ---------------------------------------------------------------
  localparam int EPQ_IN_PDP   = 0;
  localparam int EPQ_IN_CTRIP = 2;
  localparam int EPQ_IN_TTRIP = 4;
  localparam int EPQ_IN_XINT  = 6;
  localparam int EPQ_IN_CAP   = 7;
  localparam int EPQ_IN_TDIR  = 8;
endpackage

// [src/epq_qual_if.sv]
// shared sampling strobe from the divider to every input qualifier
// assumes all users sit on the one system clock
`timescale 1ns/1ps
`default_nettype none
interface epq_qual_if;
  logic sample_en;
  logic bypass;
  modport ctrl (output sample_en, output bypass);
  modport qual (input sample_en, input bypass);
endinterface
`default_nettype wire

// [src/epq_qualifier.sv]
// one input qualifier: six agreeing samples pass a new level
// assumes the pin is synchronous and the strobe comes from the top
`timescale 1ns/1ps
`default_nettype none
module epq_qualifier
  import epq_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     resetn,
  epq_qual_if.qual      cfg,
  input  wire logic     pin,
  output var  logic     level
);
  logic       pin_q;
  logic       last;
  logic [2:0] run;

  // ---------------------------------------------------------------
  // sampling
  // ---------------------------------------------------------------
  // input register, the only path into the sample logic
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) pin_q <= 1'b1;
    else         pin_q <= pin;
  end

  // run length of agreeing samples, restarted on any difference
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      last <= 1'b1;
      run  <= 3'h0;
    end else if (cfg.bypass) begin
      last <= pin_q;
      run  <= 3'h0;
    end else if (cfg.sample_en) begin
      if (pin_q != last) begin
        last <= pin_q;
        run  <= 3'h1;
      end else if (run != EPQ_QUAL_SAMPLES) begin
        run <= run + 3'h1;
      end
    end
  end

  // qualified level: sixth agreeing sample, or straight through
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) level <= 1'b1;
    else if (cfg.bypass) level <= pin_q;
    else if (cfg.sample_en && pin_q == last &&
             run == EPQ_QUAL_SAMPLES - 3'h1)
      level <= pin_q;
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_QUAL_SIX: assert property (
    (!cfg.bypass && !$past(cfg.bypass) && $changed(level)) |->
      ($past(cfg.sample_en) && $past(run) == 3'h5))
    else $error("qualified level moved without six samples");
  AST_QUAL_RESTART: assert property (
    (!cfg.bypass && cfg.sample_en && pin_q != last) |=> run == 3'h1)
    else $error("sample run did not restart on a difference");
  COV_QUAL_CHANGE: cover property (!cfg.bypass && $changed(level));
endmodule
`default_nettype wire

// [test/epq_far_model.sv]
// far side sources: protect, trip, interrupt, capture, direction pins
// assumes one bench process calls drive at a time
`timescale 1ns/1ps
`default_nettype none
module epq_far_model
  import epq_pkg::*;
(
  input  wire logic              clk,
  output var  logic [EPQ_NQ-1:0] src
);
  // ------------------------------------------------------------
  // pin drive
  // ------------------------------------------------------------
  // all sources idle high, the inactive level of every fault pin
  initial src = '1;

  // a level is held hold more edges; short holds are glitches on purpose
  task automatic drive(input int idx, input logic v, input int hold);
    @(posedge clk);
    src[idx] <= v;
    repeat (hold) @(posedge clk);
  endtask

  // no timer clock or encoder source sits on this block's pins
endmodule
`default_nettype wire

// [test/epq_top_tb.sv]
// self-checking bench for the event pin qualify and trip block
// assumes epq_far_model drives every qualified input pin
`timescale 1ns/1ps
`default_nettype none
module epq_top_tb;
  import epq_pkg::*;
  localparam int HSP = 1; // shortest tick keeps the run brief
  logic                  clk = 1'b0;
  logic                  resetn = 1'b0;
  logic [EPQ_AW-1:0]     addr = '0;
  logic [EPQ_DW-1:0]     wdata = '0;
  logic                  wr = 1'b0;
  logic                  rd = 1'b0;
  logic [EPQ_DW-1:0]     rdata;
  logic [EPQ_NQ-1:0]     src;
  logic [EPQ_NPWM-1:0]   pwm_out;
  logic [EPQ_NPWM-1:0]   pwm_oe;
  logic [EPQ_GPO_W-1:0]  gpo;
  logic                  soc_a_n;
  logic                  soc_b_n;
  logic                  tdir;
  logic                  irq;
  logic [15:0]           g;
  int                    fails = 0;
  int                    n_tests = 0;
  int                    k;
  int                    p;
  int                    d;
  int                    n;
  int                    h;
  int                    hb;

  // 25 MHz system clock
  always #20 clk = ~clk;

  // ------------------------------------------------------------
  // instances
  // ------------------------------------------------------------
  epq_far_model i_far (.clk(clk), .src(src));
  epq_top #(.HSP_DIV(HSP)) i_dut (
    .clk(clk), .resetn(resetn), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
    .power_drive_protect_input_n(src[1:0]),
    .compare_trip_input_n(src[3:2]),
    .timer_compare_trip_input_n(src[5:4]),
    .ext_int_input(src[6]), .capture_input(src[7]),
    .timer_direction_input(src[8]), .pwm_out(pwm_out), .pwm_oe(pwm_oe),
    .conv_start_pulse_a_n(soc_a_n), .conv_start_pulse_b_n(soc_b_n),
    .gpo_out(gpo), .timer_direction(tdir), .irq(irq));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one-cycle strobes, changed only just after a rising edge
  task automatic wreg(input logic [EPQ_AW-1:0] a, input logic [15:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rchk(input logic [EPQ_AW-1:0] a, input logic [15:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask

  function automatic logic probe(input int s);
    case (s)
      0: return pwm_oe[0];
      1: return irq;
      2: return tdir;
      3: return soc_a_n;
      default: return soc_b_n;
    endcase
  endfunction

  // bounded wait; k ends as the edge count until probe shows v
  task automatic meas(input int s, input logic v);
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (probe(s) !== v && k < 400);
  endtask

  function automatic int pwm_exp(input int per, input int dt);
    return (dt == 0) ? 0 : (dt >= per) ? per : dt;
  endfunction

  function automatic int soc_len();
    return EPQ_SOC_LOW_HSP * HSP;
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    summarize();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'hee09));
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    #1;
    chk({soc_a_n, soc_b_n}, 2'b11);
    chk(tdir, 1'b1);
    rchk(EPQ_REG_PERIOD, 16'h00ff);
    rchk(4'hf, 16'h0000);
    g = 16'($urandom);
    wreg(EPQ_REG_GPO, g);
    chk(gpo, g[7:0]);
    wreg(EPQ_REG_CTRL, 16'h00ff);
    rchk(EPQ_REG_CTRL, 16'h00ff);
    wreg(EPQ_REG_CTRL, 16'h0100);
    @(posedge clk);
    #1;
    chk(pwm_oe, 2'b01);
    // off, partial and full duty over one random period
    p = $urandom_range(15, 4);
    wreg(EPQ_REG_PERIOD, 16'(p));
    for (int i = 0; i < 3; i++) begin
      d = (i == 0) ? 0 : (i == 1) ? $urandom_range(p - 1, 1) : p + i;
      wreg(EPQ_REG_DUTY0, 16'(d));
      // second channel gets the complement on the partial pass
      wreg(EPQ_REG_DUTY0 + 4'h1, 16'((i == 1) ? p - d : d));
      repeat (2 * p) @(posedge clk);
      h = 0;
      hb = 0;
      repeat (p) begin
        @(posedge clk);
        #1;
        h += pwm_out[0];
        hb += pwm_out[1];
      end
      chk(16'(h), 16'(pwm_exp(p, d)));
      chk(16'(hb), 16'(pwm_exp(p, (i == 1) ? p - d : d)));
    end
    // both start pulses, low length counted edge by edge
    for (int c = 0; c < 2; c++) begin
      wreg(EPQ_REG_SOC, 16'(1 << c));
      chk(probe(3 + c), 1'b0);
      meas(3 + c, 1'b1);
      chk(16'(k), 16'(soc_len()));
    end
    // trips gate the pin only while low, enable survives
    for (int j = 0; j < 2; j++) begin
      n = j ? EPQ_IN_TTRIP : EPQ_IN_CTRIP;
      i_far.drive(n, 1'b0, 0);
      meas(0, 1'b0);
      chk(k <= 3, 1'b1);
      i_far.drive(n, 1'b1, 4);
      #1;
      chk(pwm_oe, 2'b01);
    end
    // protect latches the enable off until software rewrites it
    i_far.drive(EPQ_IN_PDP, 1'b0, 0);
    meas(0, 1'b0);
    chk(k <= 3, 1'b1);
    i_far.drive(EPQ_IN_PDP, 1'b1, 6);
    #1;
    chk(pwm_oe, 2'b00);
    rchk(EPQ_REG_STATUS, 16'h0015);
    wreg(EPQ_REG_CTRL, 16'h0300);
    @(posedge clk);
    #1;
    chk(pwm_oe, 2'b11);
    // interrupt raised, read-cleared, then masked out
    wreg(EPQ_REG_MASK, 16'h0040);
    i_far.drive(EPQ_IN_XINT, 1'b0, 0);
    meas(1, 1'b1);
    chk(k <= 4, 1'b1);
    i_far.drive(EPQ_IN_CAP, 1'b0, 3);
    rchk(EPQ_REG_LEVEL, 16'h013f);
    rchk(EPQ_REG_STATUS, 16'h00c0);
    @(posedge clk);
    #1;
    chk(irq, 1'b0);
    wreg(EPQ_REG_MASK, 16'h0080);
    i_far.drive(EPQ_IN_XINT, 1'b1, 6);
    #1;
    chk(irq, 1'b0);
    i_far.drive(EPQ_IN_CAP, 1'b1, 6);
    #1;
    chk(irq, 1'b1);
    rchk(EPQ_REG_STATUS, 16'h00c0);
    // qualified: short low run, one differing sample, then a real fall
    n = $urandom_range(3, 1);
    wreg(EPQ_REG_CTRL, 16'h0100 | 16'(n));
    i_far.drive(EPQ_IN_TDIR, 1'b0, 8 * n - 2);
    i_far.drive(EPQ_IN_TDIR, 1'b1, 2 * n - 1);
    i_far.drive(EPQ_IN_TDIR, 1'b0, 0);
    meas(2, 1'b0);
    chk(k >= 10 * n && k <= 12 * n + 3, 1'b1);
    i_far.drive(EPQ_IN_TDIR, 1'b1, 0);
    meas(2, 1'b1);
    chk(k >= 10 * n && k <= 12 * n + 3, 1'b1);
    // qualified trip: release waits for six agreeing samples
    i_far.drive(EPQ_IN_CTRIP, 1'b0, 0);
    meas(0, 1'b0);
    chk(k >= 10 * n && k <= 12 * n + 3, 1'b1);
    summarize();
  end
endmodule
`default_nettype wire
